// *** osc_crystal_model.sv ***
// behavioural high- and low-speed crystals that feed the warm-up counter
`timescale 1ns/1ps
`default_nettype none
module osc_crystal_model #(
   parameter int HS_HALF = 20, // ns, keeps the crystal under 50 MHz
   parameter int LS_HALF = 30 // ns, distinct rate shows a wrong source
) (
   input wire logic hsRun, // high-speed oscillator enable
   input wire logic lsRun, // low-speed oscillator enable
   output var logic hsClk, // high-speed crystal input
   output var logic lsClk // low-speed crystal input
);
   // a stopped crystal stands still low, so counting it would hang warm-up
   always begin
      if (hsRun === 1'b1) begin
         #HS_HALF hsClk = (hsClk === 1'b1) ? 1'b0 : 1'b1;
      end else begin
         hsClk = 1'b0;
         @(hsRun);
      end
   end
   always begin
      if (lsRun === 1'b1) begin
         #LS_HALF lsClk = (lsClk === 1'b1) ? 1'b0 : 1'b1;
      end else begin
         lsClk = 1'b0;
         @(lsRun);
      end
   end
endmodule : osc_crystal_model
`default_nettype wire

// *** osc_warmup_pkg.sv ***
// constants, field layouts and carriers for the oscillator/standby control unit
package osc_warmup_pkg;
   localparam logic [7:0] OSC_CTRL_OFFSET = 8'h04;
   localparam logic [7:0] LOW_POWER_MODE_SELECT_CTRL_OFFSET = 8'h08;
   // oscillator_control field positions
   localparam int OSC_START_BIT = 0;
   localparam int OSC_BUSY_BIT = 1;
   localparam int OSC_PLL_BIT = 2;
   localparam int OSC_SEL_BIT = 3;
   localparam int OSC_TIME_LSB = 4;
   localparam int OSC_HS_EN_BIT = 8;
   localparam int OSC_LS_EN_BIT = 9;
   localparam int OSC_SPARE_LSB = 12;
   // standby_control field positions
   localparam int LOW_POWER_MODE_SELECT_MODE_LSB = 0;
   localparam int LOW_POWER_MODE_SELECT_WAKE_HS_BIT = 8;
   localparam int LOW_POWER_MODE_SELECT_WAKE_LS_BIT = 9;
   localparam int LOW_POWER_MODE_SELECT_PIN_BIT = 16;
   localparam int LOW_POWER_MODE_SELECT_SPARE_BIT = 17;
   // low-power mode codes, then the warm-up time code for none
   localparam logic [2:0] MODE_STOP = 3'h1;
   localparam logic [2:0] MODE_SLEEP = 3'h2;
   localparam logic [2:0] MODE_IDLE = 3'h3;
   localparam logic [2:0] TIME_NONE = 3'h0;
   // warm-up length exponents
   localparam logic [4:0] HS_EXP_BASE = 5'h09;
   localparam logic [4:0] LS_EXP_SHORT_BASE = 5'h05;
   localparam logic [4:0] LS_EXP_LONG_BASE = 5'h0b;
   localparam logic [2:0] LS_LONG_FIRST = 3'h4;
   localparam int WARM_CNT_W = 19;

   typedef struct packed {
      logic [1:0] spare;
      logic lsEnable;
      logic hsEnable;
      logic [2:0] warmupTime;
      logic warmupSel;
      logic pllRun;
   } osc_ctrl_s;

   typedef struct packed {
      logic spare;
      logic pinDrive;
      logic wakeLs;
      logic wakeHs;
      logic [2:0] mode;
   } low_power_mode_select_ctrl_s;

   typedef struct packed {
      logic hsOscRun;
      logic lsOscRun;
      logic pllRun;
      logic cpuClkRun;
   } clk_enables_s;

   localparam osc_ctrl_s OSC_CTRL_RESET = '{spare: 2'h0, lsEnable: 1'b1,
      hsEnable: 1'b1, warmupTime: 3'h1, warmupSel: 1'b0, pllRun: 1'b0};
   localparam low_power_mode_select_ctrl_s LOW_POWER_MODE_SELECT_CTRL_RESET = '{spare: 1'b0, pinDrive: 1'b0,
      wakeLs: 1'b0, wakeHs: 1'b1, mode: 3'h3};
endpackage : osc_warmup_pkg

// *** osc_warmup_standby_ctrl.sv ***
// oscillator enables, warm-up timer and standby mode control behind wishbone
// Functional notes
// - warm-up source select 0 counts high-speed input, 1 low-speed input.
// - warm-up timer counts only edges of the selected oscillator.
// - high-speed lengths: 000 none, 001..111 give 2^10..2^16 cycles.
// - low-speed lengths: 000 none, 2^6..2^8, then 2^15..2^18 cycles.
// - pll run bit 1 starts the PLL, 0 stops it.
// - pll run bit resets to 0; software sets it before PLL use.
// - read-only busy flag is 1 while warm-up counts, 0 when done.
// - writing 1 to warm-up start begins warm-up; writing 0 does nothing.
// - stop pin drive bit: 0 pins inactive in stop, 1 active; resets 0.
// - wake low-speed bit sets low-speed oscillator after stop; resets 0.
// - wake high-speed bit sets that oscillator after stop; resets 1.
// - mode 001 stop, 010 sleep, 011 idle, others reserved; resets 011.
// - wake from stop/sleep starts warm-up; cpu clock only after it ends.
// - PLL kept disabled while in stop or sleep mode.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module osc_warmup_standby_ctrl (
   input wire logic sys_clk, // system clock, 100 MHz
   input wire logic rst_n, // asynchronous reset
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic hsOscClk, // high-speed crystal input
   input wire logic lsOscClk, // low-speed crystal input
   input wire logic standbyReq, // cpu asks to enter low power
   input wire logic wakeIrq, // wake-up interrupt
   output osc_warmup_pkg::clk_enables_s clkEnables, // oscillator/pll/cpu
   output logic pinsActive, // pin drivers enabled
   output logic warmupBusy // warm-up counting
);
   import osc_warmup_pkg::*;

   typedef enum logic [2:0] {
      ST_RUN, ST_IDLE, ST_SLEEP, ST_STOP, ST_WAKE
   } power_state_e;

   osc_ctrl_s osc, next_osc;
   low_power_mode_select_ctrl_s low_power_mode_select, next_low_power_mode_select;
   power_state_e state, next_state;
   logic busy, next_busy;
   logic [WARM_CNT_W-1:0] cnt, next_cnt;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic [2:0] newTime;
   logic [1:0] oscIn;
   logic [1:0] oscEdge;
   logic srcEdge;
   logic [WARM_CNT_W-1:0] target;
   logic [31:0] wmask;
   logic [31:0] oscImage, stbyImage;
   logic [31:0] oscWr, stbyWr;
   logic wrStrobe, wrOsc, wrStby, startWrite, wakeStart, startCount;

   assign oscIn = {lsOscClk, hsOscClk};

   // oscillator inputs are async to sys_clk; the first flop feeds only the
   // second. edges are seen only while the crystal is slower than fsys/2.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_osc_sync
         logic sync1, sync2, sync3;
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               sync1 <= 1'b0;
               sync2 <= 1'b0;
               sync3 <= 1'b0;
            end else begin
               sync1 <= oscIn[g];
               sync2 <= sync1;
               sync3 <= sync2;
            end
         end
         assign oscEdge[g] = sync2 & ~sync3;
         assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
         assign wmask[8*(g+2) +: 8] = {8{wb_sel_i[g+2]}};
      end
   endgenerate

   assign srcEdge = osc.warmupSel ? oscEdge[1] : oscEdge[0];

   // length in source cycles for the selected code and source
   always_comb begin
      target = '0;
      if (!osc.warmupSel) begin
         target[HS_EXP_BASE + 5'(osc.warmupTime)] = 1'b1;
      end else if (osc.warmupTime < LS_LONG_FIRST) begin
         target[LS_EXP_SHORT_BASE + 5'(osc.warmupTime)] = 1'b1;
      end else begin
         target[LS_EXP_LONG_BASE + 5'(osc.warmupTime)] = 1'b1;
      end
   end

   // register images; unused bits read as zero
   always_comb begin
      oscImage = '0;
      oscImage[OSC_BUSY_BIT] = busy;
      oscImage[OSC_PLL_BIT] = osc.pllRun;
      oscImage[OSC_SEL_BIT] = osc.warmupSel;
      oscImage[OSC_TIME_LSB +: 3] = osc.warmupTime;
      oscImage[OSC_HS_EN_BIT] = osc.hsEnable;
      oscImage[OSC_LS_EN_BIT] = osc.lsEnable;
      oscImage[OSC_SPARE_LSB +: 2] = osc.spare;
      stbyImage = '0;
      stbyImage[LOW_POWER_MODE_SELECT_MODE_LSB +: 3] = low_power_mode_select.mode;
      stbyImage[LOW_POWER_MODE_SELECT_WAKE_HS_BIT] = low_power_mode_select.wakeHs;
      stbyImage[LOW_POWER_MODE_SELECT_WAKE_LS_BIT] = low_power_mode_select.wakeLs;
      stbyImage[LOW_POWER_MODE_SELECT_PIN_BIT] = low_power_mode_select.pinDrive;
      stbyImage[LOW_POWER_MODE_SELECT_SPARE_BIT] = low_power_mode_select.spare;
   end

   assign oscWr = (oscImage & ~wmask) | (wb_dat_i & wmask);
   assign stbyWr = (stbyImage & ~wmask) | (wb_dat_i & wmask);
   // writes land on the edge where ack is high, as classic wishbone expects
   assign wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & ack;
   assign wrOsc = wrStrobe & (wb_adr_i == OSC_CTRL_OFFSET);
   assign wrStby = wrStrobe & (wb_adr_i == LOW_POWER_MODE_SELECT_CTRL_OFFSET);
   assign startWrite = wrOsc & wb_sel_i[0] & wb_dat_i[OSC_START_BIT];
   assign wakeStart = wakeIrq & ((state == ST_SLEEP) | (state == ST_STOP));
   assign startCount = startWrite | wakeStart;
   // a start written together with a new code must use the new code
   assign newTime = wrOsc ? oscWr[OSC_TIME_LSB +: 3] : osc.warmupTime;

   // bus answer: one wait state, ack one cycle, unmapped reads give zero
   always_comb begin
      next_ack = wb_cyc_i & wb_stb_i & ~ack;
      next_rdata = rdata;
      if (wb_cyc_i & wb_stb_i & ~ack) begin
         unique case (wb_adr_i)
            OSC_CTRL_OFFSET: next_rdata = oscImage;
            LOW_POWER_MODE_SELECT_CTRL_OFFSET: next_rdata = stbyImage;
            default: next_rdata = '0;
         endcase
      end
   end

   // software fields; stop release reloads the oscillator enables
   always_comb begin
      next_osc = osc;
      next_low_power_mode_select = low_power_mode_select;
      if (wrOsc) begin
         next_osc.pllRun = oscWr[OSC_PLL_BIT];
         next_osc.warmupSel = oscWr[OSC_SEL_BIT];
         next_osc.warmupTime = oscWr[OSC_TIME_LSB +: 3];
         next_osc.hsEnable = oscWr[OSC_HS_EN_BIT];
         next_osc.lsEnable = oscWr[OSC_LS_EN_BIT];
         next_osc.spare = oscWr[OSC_SPARE_LSB +: 2];
      end
      if (wrStby) begin
         next_low_power_mode_select.mode = stbyWr[LOW_POWER_MODE_SELECT_MODE_LSB +: 3];
         next_low_power_mode_select.wakeHs = stbyWr[LOW_POWER_MODE_SELECT_WAKE_HS_BIT];
         next_low_power_mode_select.wakeLs = stbyWr[LOW_POWER_MODE_SELECT_WAKE_LS_BIT];
         next_low_power_mode_select.pinDrive = stbyWr[LOW_POWER_MODE_SELECT_PIN_BIT];
         next_low_power_mode_select.spare = stbyWr[LOW_POWER_MODE_SELECT_SPARE_BIT];
      end
      if (wakeIrq && state == ST_STOP) begin
         next_osc.hsEnable = low_power_mode_select.wakeHs;
         next_osc.lsEnable = low_power_mode_select.wakeLs;
      end
   end

   // warm-up counter; a start in the same cycle as completion restarts it
   always_comb begin
      next_busy = busy;
      next_cnt = cnt;
      if (busy && srcEdge) begin
         next_cnt = cnt + 1'b1;
         if (cnt + 1'b1 == target) begin
            next_busy = 1'b0;
         end
      end
      if (startCount) begin
         next_cnt = '0;
         next_busy = (newTime != TIME_NONE);
      end
   end

   // power state; reserved mode codes make a standby request do nothing
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (standbyReq) begin
               unique case (low_power_mode_select.mode)
                  MODE_STOP: next_state = ST_STOP;
                  MODE_SLEEP: next_state = ST_SLEEP;
                  MODE_IDLE: next_state = ST_IDLE;
                  default: next_state = ST_RUN;
               endcase
            end
         end
         ST_IDLE: if (wakeIrq) next_state = ST_RUN;
         ST_SLEEP, ST_STOP: begin
            if (wakeIrq) begin
               next_state = (newTime == TIME_NONE) ? ST_RUN : ST_WAKE;
            end
         end
         ST_WAKE: if (!busy) next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc <= OSC_CTRL_RESET;
         low_power_mode_select <= LOW_POWER_MODE_SELECT_CTRL_RESET;
         state <= ST_RUN;
         busy <= 1'b0;
         cnt <= '0;
         ack <= 1'b0;
         rdata <= '0;
      end else begin
         osc <= next_osc;
         low_power_mode_select <= next_low_power_mode_select;
         state <= next_state;
         busy <= next_busy;
         cnt <= next_cnt;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // stop halts both crystals, sleep only the high-speed one
   always_comb begin
      clkEnables.hsOscRun = osc.hsEnable & (state != ST_STOP)
         & (state != ST_SLEEP);
      clkEnables.lsOscRun = osc.lsEnable & (state != ST_STOP);
      clkEnables.pllRun = osc.pllRun & (state != ST_STOP)
         & (state != ST_SLEEP);
      clkEnables.cpuClkRun = (state == ST_RUN);
      pinsActive = (state != ST_STOP) | low_power_mode_select.pinDrive;
   end

   assign warmupBusy = busy;
   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;


   // checks on the block's own state, all sampled on sys_clk
   AST_ACK_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   AST_PLL_LOW_POWER: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state == ST_STOP || state == ST_SLEEP) |-> !clkEnables.pllRun)
      else $error("pll running in stop or sleep");
   AST_PLL_WRITE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (wrOsc && wb_sel_i[0]) |=>
      osc.pllRun == $past(wb_dat_i[OSC_PLL_BIT]))
      else $error("pll bit not taken from write");
   AST_START_BUSY: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (startWrite && newTime != TIME_NONE) |=> busy && cnt == '0)
      else $error("start did not begin warm-up");
   AST_START_IGNORED: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (wrOsc && !startWrite && !wakeStart && !busy) |=> !busy)
      else $error("write without start bit began warm-up");
   AST_TIME_NONE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (startCount && newTime == TIME_NONE) |=> !busy)
      else $error("code zero began warm-up");
   AST_COUNT_SOURCE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (busy && !srcEdge && !startCount) |=> $stable(cnt) && busy)
      else $error("warm-up count moved without source edge");
   AST_BUSY_DONE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (busy && srcEdge && !startCount && cnt == target - 1'b1) |=> !busy)
      else $error("busy not cleared at warm-up end");
   AST_WAKE_START: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (wakeStart && newTime != TIME_NONE) |=> busy && state == ST_WAKE)
      else $error("wake did not begin warm-up");
   AST_WAKE_HOLD: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state == ST_WAKE) |-> !clkEnables.cpuClkRun ##1
      (state == ST_WAKE || state == ST_RUN))
      else $error("cpu clock given during warm-up");
   AST_STOP_RELEASE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state == ST_STOP && wakeIrq) |=>
      osc.hsEnable == $past(low_power_mode_select.wakeHs) &&
      osc.lsEnable == $past(low_power_mode_select.wakeLs))
      else $error("oscillators not set from wake bits");
   AST_OSC_WRITE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (wrOsc && wb_sel_i[1] && !(state == ST_STOP && wakeIrq)) |=>
      osc.hsEnable == $past(wb_dat_i[OSC_HS_EN_BIT]) &&
      osc.lsEnable == $past(wb_dat_i[OSC_LS_EN_BIT]))
      else $error("oscillator enables not taken from write");
   AST_MODE_RESERVED: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state == ST_RUN && standbyReq &&
      (low_power_mode_select.mode == 3'h0 || low_power_mode_select.mode > 3'h3)) |=> state == ST_RUN)
      else $error("reserved mode entered low power");
   AST_PIN_DRIVE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state == ST_STOP) |-> pinsActive == low_power_mode_select.pinDrive)
      else $error("pin drive wrong in stop");
endmodule : osc_warmup_standby_ctrl
`default_nettype wire

// *** tb_osc_warmup_standby_ctrl.sv ***
// self-checking bench for the oscillator and standby control unit
`timescale 1ns/1ps
`default_nettype none
module tb_osc_warmup_standby_ctrl;
   import osc_warmup_pkg::*;
   typedef struct {
      logic [7:0] adr;
      logic [31:0] wdat;
      logic [3:0] sel;
      logic [31:0] rdat;
   } row_s;
   logic sys_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, hsClk, lsClk;
   logic standbyReq, wakeIrq, pinsActive, warmupBusy;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, rd;
   clk_enables_s clkEn;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   // byte-lane row leaves both oscillators stopped; reset follows it
   row_s rows [6] = '{'{8'h04, 32'h00001314, 4'hf, 32'h00001314},
      '{8'h04, 32'hfffffffa, 4'hf, 32'h00003378},
      '{8'h08, 32'hffffffff, 4'hf, 32'h00030307},
      '{8'h08, 32'h00000000, 4'h1, 32'h00030300},
      '{8'h0c, 32'hffffffff, 4'hf, 32'h00000000},
      '{8'h04, 32'h00000000, 4'h2, 32'h00000078}};

   osc_warmup_standby_ctrl i_osc_warmup_standby_ctrl (.sys_clk(sys_clk),
      .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .hsOscClk(hsClk),
      .lsOscClk(lsClk), .standbyReq(standbyReq), .wakeIrq(wakeIrq),
      .clkEnables(clkEn), .pinsActive(pinsActive),
      .warmupBusy(warmupBusy));
   osc_crystal_model i_osc_crystal_model (.hsRun(clkEn.hsOscRun),
      .lsRun(clkEn.lsOscRun), .hsClk(hsClk), .lsClk(lsClk));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // whole run needs about 10000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         $display("[FAIL] run length expected done seen hang");
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : tick

   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      wbSel <= s;
      do @(posedge sys_clk); while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb

   task automatic settle(output int k);
      k = 0;
      while (warmupBusy !== 1'b0) begin
         @(posedge sys_clk);
         k++;
      end
   endtask : settle

   // e is the crystal edge count times its period in system cycles
   task automatic warm(input logic [31:0] v, input int e, input string what);
      int k;
      wb(1'b1, OSC_CTRL_OFFSET, v, 4'hf);
      tick(1);
      chk("busy port", warmupBusy, 1'b1);
      wb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'hf);
      chk("busy flag", rd[1:0], 2'b10);
      settle(k);
      chk(what, k >= e - 8 && k <= e + 16, 1'b1);
      $display("test %s done", what);
   endtask : warm

   task automatic enter(input logic [31:0] v);
      wb(1'b1, LOW_POWER_MODE_SELECT_CTRL_OFFSET, v, 4'hf);
      @(posedge sys_clk);
      standbyReq <= 1'b1;
      @(posedge sys_clk);
      standbyReq <= 1'b0;
      tick(2);
   endtask : enter

   task automatic wake();
      @(posedge sys_clk);
      wakeIrq <= 1'b1;
      @(posedge sys_clk);
      wakeIrq <= 1'b0;
      tick(1);
   endtask : wake

   initial begin
      rst_n = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbSel = 4'h0;
      wbDatI = 32'h0;
      standbyReq = 1'b0;
      wakeIrq = 1'b0;
      tick(4);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, rows[i].wdat, rows[i].sel);
         wb(1'b0, rows[i].adr, 32'h0, 4'hf);
         chk("row read", rd, rows[i].rdat);
      end
      $display("test register rows done");
      @(posedge sys_clk);
      rst_n <= 1'b0;
      tick(2);
      chk("reset outputs", {clkEn, pinsActive, warmupBusy}, 6'h36);
      tick(2);
      rst_n <= 1'b1;
      wb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'hf);
      chk("osc reset", rd, 32'h00000310);
      wb(1'b0, LOW_POWER_MODE_SELECT_CTRL_OFFSET, 32'h0, 4'hf);
      chk("low_power_mode_select reset", rd, 32'h00000103);
      $display("test reset values done");
      warm(32'h00000315, 4096, "hs code 1");
      wb(1'b1, OSC_CTRL_OFFSET, 32'h00000314, 4'hf);
      tick(3);
      chk("start written 0", warmupBusy, 1'b0);
      wb(1'b1, OSC_CTRL_OFFSET, 32'h00000305, 4'hf);
      tick(3);
      chk("code 000", warmupBusy, 1'b0);
      for (int c = 1; c < 4; c++) begin
         warm(32'h309 | (c << 4), 6 << (5 + c), "ls code");
      end
      wb(1'b1, OSC_CTRL_OFFSET, 32'h0000031c, 4'hf);
      enter(32'h00000203);
      chk("idle", clkEn, 4'he);
      wake();
      chk("idle wake", clkEn, 4'hf);
      enter(32'h00000202);
      chk("sleep", {clkEn, pinsActive}, 5'h09);
      wake();
      chk("sleep wake", {warmupBusy, clkEn.cpuClkRun}, 2'b10);
      settle(n);
      tick(2);
      chk("sleep done", clkEn, 4'hf);
      enter(32'h00000201);
      chk("stop", {clkEn, pinsActive}, 5'h00);
      wake();
      settle(n);
      tick(2);
      chk("stop done", clkEn, 4'h7);
      wb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'hf);
      chk("osc after stop", rd[9:8], 2'b10);
      enter(32'h00010301);
      chk("stop drive", pinsActive, 1'b1);
      wake();
      settle(n);
      wb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'hf);
      chk("osc after stop 2", rd[9:8], 2'b11);
      enter(32'h00000207);
      chk("reserved mode", clkEn.cpuClkRun, 1'b1);
      $display("test power modes done");
      wb(1'b1, OSC_CTRL_OFFSET, 32'h0000034d, 4'hf);
      tick(2000);
      chk("ls code 4 long", warmupBusy, 1'b1);
      $display("test long warm-up done");
      wrap_up();
   end
endmodule : tb_osc_warmup_standby_ctrl
`default_nettype wire
